// file: design/cbsl_top.sv
// Socket-side CardBus framing, claiming, parity, arbitration and lock forwarding.
// Assumes clk is the CardBus clock; every card pin arrives unsynchronised.
`timescale 1ns/10ps

// Notes on behaviour
// - As initiator, watch device select; with no claim by timeout, abort the cycle.
// - As target, claim the cycle by asserting device select.
// - Frame starts a transaction, stays low while data follows, rises on the last phase.
// - A data phase ends only when initiator and target ready are both low.
// - A target drives parity error low two clocks after bad data, never on special cycles.
// - Grant goes to a requesting card only after the current transaction ends.
// - A card system error may be relayed as a system error pulse upstream.
// - In binary audio mode the card audio passes to speaker_out.
// - Status change notifies the host and acts as a wake-up source.
// - Card detect and voltage sense give insertion and card voltage.
// - Lock shares general_purpose_pin_two, which is an input after reset.
// - Locks are forwarded only downstream, from host toward card.
// - While locked, other transactions still reach addresses outside the locked region.
// - Winning arbitration does not confer lock ownership.
// - A lock covers one aligned 16-byte region.
// - Exclusive access on the card side uses the card lock line.
// - Write posting is disabled while a lock is in progress.
module cbsl_top (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire cbsl_pkg::cbsl_ctl_s cb_i,
  output wire cbsl_pkg::cbsl_ctl_s cb_o,
  output wire cbsl_pkg::cbsl_ctl_s cb_oe_n,
  input  wire logic [31:0]         ad_i,
  input  wire logic [3:0]          cbe_i,
  input  wire logic                par_i,
  output wire logic [31:0]         ad_o,
  output wire logic [3:0]          cbe_o,
  output wire logic                ad_oe_n,
  input  wire cbsl_pkg::cbsl_sb_s  sb_i,
  output wire logic                cgnt_n,
  input  wire logic [15:0]         tgt_base,
  input  wire logic                req_valid,
  input  wire cbsl_pkg::cbsl_req_s req,
  output wire cbsl_pkg::cbsl_ans_s ans,
  input  wire logic                lock_fn_en,
  input  wire logic                serr_en,
  input  wire logic                audio_bin_en,
  output wire cbsl_pkg::cbsl_st_s  st
);

  cbsl_pkg::cbsl_ctl_s cb_m, cb_s, cb_o_r, cb_o_nxt, oe_r, oe_nxt;
  cbsl_pkg::cbsl_sb_s  sb_m, sb_s;
  cbsl_pkg::cbsl_st_s  st_r, st_nxt;
  cbsl_pkg::cbsl_ans_s ans_r, ans_nxt;
  cbsl_pkg::cbsl_req_s req_q_r, req_q_nxt;
  cbsl_pkg::cbsl_ini_e ini_r, ini_nxt;
  cbsl_pkg::cbsl_tgt_e tgt_r, tgt_nxt;
  logic [31:0]         ad_m, ad_s;
  logic [3:0]          cbe_m, cbe_s;
  logic                par_m, par_s;
  logic [2:0]          cnt_r, cnt_nxt;
  logic [3:0]          rem_r, rem_nxt;
  logic [27:0]         region_r, region_nxt;
  logic                lock_act_r, lock_act_nxt;
  logic                gnt_n_r, gnt_nxt;
  logic                par_chk_r, par_chk_nxt;
  logic                par_calc_r, par_calc_nxt;
  logic                ad_oe_r, ad_oe_nxt;
  logic                lock_fn_r;
  logic                frame_d_r;
  logic                cserr_d_r;
  logic                ini_xfer, tgt_xfer, bus_idle, hit_lock, claimed, perr_nxt;

  assign cb_o    = cb_o_r;
  assign cb_oe_n = oe_r;
  assign ad_o    = req_q_r.addr;
  assign cbe_o   = req_q_r.cmd;
  assign ad_oe_n = ad_oe_r;
  assign cgnt_n  = gnt_n_r;
  assign ans     = ans_r;
  assign st      = st_r;

  // Two-stage synchronisers for every card pin.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cb_m  <= cbsl_pkg::CTL_RST;
      cb_s  <= cbsl_pkg::CTL_RST;
      sb_m  <= cbsl_pkg::SB_RST;
      sb_s  <= cbsl_pkg::SB_RST;
      ad_m  <= 32'h0;
      ad_s  <= 32'h0;
      cbe_m <= 4'h0;
      cbe_s <= 4'h0;
      par_m <= 1'b0;
      par_s <= 1'b0;
    end else begin
      cb_m  <= cb_i;
      cb_s  <= cb_m;
      sb_m  <= sb_i;
      sb_s  <= sb_m;
      ad_m  <= ad_i;
      ad_s  <= ad_m;
      cbe_m <= cbe_i;
      cbe_s <= cbe_m;
      par_m <= par_i;
      par_s <= par_m;
    end
  end

  always_comb begin
    ini_nxt      = ini_r;
    tgt_nxt      = tgt_r;
    cnt_nxt      = cnt_r;
    rem_nxt      = rem_r;
    req_q_nxt    = req_q_r;
    region_nxt   = region_r;
    lock_act_nxt = lock_act_r;
    gnt_nxt      = gnt_n_r;
    cb_o_nxt     = cbsl_pkg::CTL_RST;
    oe_nxt       = cbsl_pkg::CTL_RST;
    ad_oe_nxt    = 1'b1;
    ans_nxt      = cbsl_pkg::ANS_RST;
    st_nxt       = cbsl_pkg::ST_RST;
    ini_xfer     = !cb_o_r.irdy_n && !cb_s.trdy_n;
    tgt_xfer     = !cb_s.irdy_n && !cb_o_r.trdy_n;
    bus_idle     = cb_s.frame_n && cb_s.irdy_n;
    hit_lock     = lock_act_r && (req.addr[31:cbsl_pkg::LOCK_LSB] == region_r);
    claimed      = (ini_r == cbsl_pkg::I_DATA) || !cb_s.devsel_n;

    case (ini_r)
      cbsl_pkg::I_IDLE: begin
        // A grant held by the card keeps the host off the bus.
        if (req_valid && gnt_n_r && bus_idle && tgt_r == cbsl_pkg::T_IDLE) begin
          if (hit_lock && !req.locked) begin
            ans_nxt.retry = 1'b1;
          end else begin
            req_q_nxt = req;
            rem_nxt   = (req.len == 4'h0) ? cbsl_pkg::LEN_ONE : req.len;
            cnt_nxt   = 3'h0;
            ini_nxt   = cbsl_pkg::I_ADDR;
            // Lock is taken by its own protocol, not by winning the bus.
            if (req.locked && lock_fn_r && !sb_s.gp2 && !lock_act_r) begin
              lock_act_nxt = 1'b1;
              region_nxt   = req.addr[31:cbsl_pkg::LOCK_LSB];
            end
          end
        end
      end
      cbsl_pkg::I_ADDR: begin
        ini_nxt = cbsl_pkg::I_WAIT;
      end
      cbsl_pkg::I_WAIT, cbsl_pkg::I_DATA: begin
        if (!claimed) begin
          cnt_nxt = cnt_r + 3'h1;
          if (cnt_nxt == cbsl_pkg::DEVSEL_TO_CLKS) begin
            ans_nxt.abort = 1'b1;
            ini_nxt       = cbsl_pkg::I_END;
          end
        end else begin
          ini_nxt = cbsl_pkg::I_DATA;
          if (ini_xfer) begin
            rem_nxt = rem_r - 4'h1;
            if (rem_r == cbsl_pkg::LEN_ONE) begin
              ans_nxt.done = 1'b1;
              ini_nxt      = cbsl_pkg::I_END;
            end
          end
          if (!cb_s.stop_n && ini_nxt != cbsl_pkg::I_END) begin
            // Target disconnect: stop after this phase.
            ans_nxt.done = 1'b1;
            ini_nxt      = cbsl_pkg::I_END;
          end
        end
      end
      cbsl_pkg::I_END: begin
        ini_nxt = cbsl_pkg::I_IDLE;
      end
      default: begin
        ini_nxt = cbsl_pkg::I_IDLE;
      end
    endcase

    // Pins follow the next state so they change with it.
    case (ini_nxt)
      cbsl_pkg::I_ADDR: begin
        cb_o_nxt.frame_n = 1'b0;
        oe_nxt.frame_n   = 1'b0;
        oe_nxt.irdy_n    = 1'b0;
        ad_oe_nxt        = 1'b0;
      end
      cbsl_pkg::I_WAIT, cbsl_pkg::I_DATA: begin
        cb_o_nxt.frame_n = (rem_nxt == cbsl_pkg::LEN_ONE);
        cb_o_nxt.irdy_n  = 1'b0;
        oe_nxt.frame_n   = 1'b0;
        oe_nxt.irdy_n    = 1'b0;
      end
      cbsl_pkg::I_END: begin
        oe_nxt.frame_n = 1'b0;
        oe_nxt.irdy_n  = 1'b0;
      end
      default: begin
        ad_oe_nxt = 1'b1;
      end
    endcase

    // Card-initiated cycles are upstream and never touch the lock.
    case (tgt_r)
      cbsl_pkg::T_IDLE: begin
        if (!cb_s.frame_n && frame_d_r && ini_r == cbsl_pkg::I_IDLE &&
            ad_s[31:cbsl_pkg::TGT_LSB] == tgt_base && cbe_s != cbsl_pkg::CMD_SPECIAL) begin
          tgt_nxt = cbsl_pkg::T_DATA;
        end
      end
      cbsl_pkg::T_DATA: begin
        if (tgt_xfer && cb_s.frame_n) begin
          tgt_nxt = cbsl_pkg::T_END;
        end
      end
      default: begin
        tgt_nxt = cbsl_pkg::T_IDLE;
      end
    endcase
    if (tgt_nxt == cbsl_pkg::T_DATA) begin
      cb_o_nxt.devsel_n = 1'b0;
      cb_o_nxt.trdy_n   = 1'b0;
    end
    if (tgt_nxt != cbsl_pkg::T_IDLE) begin
      oe_nxt.devsel_n = 1'b0;
      oe_nxt.trdy_n   = 1'b0;
    end

    // Parity follows its data by one clock, so the error lands two after.
    par_chk_nxt      = tgt_xfer;
    par_calc_nxt     = ^{ad_s, cbe_s};
    perr_nxt         = par_chk_r && (par_calc_r != par_s);
    cb_o_nxt.perr_n  = !perr_nxt;
    oe_nxt.perr_n    = !(perr_nxt || !cb_o_r.perr_n || tgt_nxt != cbsl_pkg::T_IDLE);

    if (!lock_fn_r || !lock_fn_en || (sb_s.gp2 && ini_r == cbsl_pkg::I_IDLE)) begin
      lock_act_nxt = 1'b0;
    end
    cb_o_nxt.lock_n = !lock_act_nxt;
    oe_nxt.lock_n   = !lock_act_nxt;

    // Waiting for an idle bus keeps a grant from cutting a transaction.
    if (sb_s.creq_n) begin
      gnt_nxt = 1'b1;
    end else if (bus_idle && ini_nxt == cbsl_pkg::I_IDLE && tgt_r == cbsl_pkg::T_IDLE) begin
      gnt_nxt = 1'b0;
    end

    ans_nxt.busy                 = (ini_nxt != cbsl_pkg::I_IDLE);
    // Only the falling edge reports, so a slow pull-up release is harmless.
    st_nxt.pci_serr_n            = !(serr_en && !sb_s.cserr_n && cserr_d_r);
    st_nxt.speaker_out           = audio_bin_en && sb_s.caudio;
    st_nxt.card_irq              = !sb_s.cint_n;
    st_nxt.stschg                = sb_s.cstschg;
    st_nxt.wake                  = sb_s.cstschg && !st_r.stschg;
    st_nxt.present               = !sb_s.cd1_n && !sb_s.cd2_n;
    st_nxt.vs                    = st_nxt.present ? {sb_s.vs2, sb_s.vs1} : 2'h0;
    st_nxt.general_purpose_input = !lock_fn_r && sb_s.gp2;
    st_nxt.posting_en            = !lock_act_nxt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ini_r      <= cbsl_pkg::I_IDLE;
      tgt_r      <= cbsl_pkg::T_IDLE;
      cnt_r      <= 3'h0;
      rem_r      <= 4'h0;
      req_q_r    <= cbsl_pkg::REQ_RST;
      region_r   <= 28'h0;
      lock_act_r <= 1'b0;
      gnt_n_r    <= 1'b1;
      par_chk_r  <= 1'b0;
      par_calc_r <= 1'b0;
      cb_o_r     <= cbsl_pkg::CTL_RST;
      oe_r       <= cbsl_pkg::CTL_RST;
      ad_oe_r    <= 1'b1;
      ans_r      <= cbsl_pkg::ANS_RST;
      st_r       <= cbsl_pkg::ST_RST;
      lock_fn_r  <= 1'b0;
      frame_d_r  <= 1'b1;
      cserr_d_r  <= 1'b1;
    end else begin
      ini_r      <= ini_nxt;
      tgt_r      <= tgt_nxt;
      cnt_r      <= cnt_nxt;
      rem_r      <= rem_nxt;
      req_q_r    <= req_q_nxt;
      region_r   <= region_nxt;
      lock_act_r <= lock_act_nxt;
      gnt_n_r    <= gnt_nxt;
      par_chk_r  <= par_chk_nxt;
      par_calc_r <= par_calc_nxt;
      cb_o_r     <= cb_o_nxt;
      oe_r       <= oe_nxt;
      ad_oe_r    <= ad_oe_nxt;
      ans_r      <= ans_nxt;
      st_r       <= st_nxt;
      lock_fn_r  <= lock_fn_en;
      frame_d_r  <= cb_s.frame_n;
      cserr_d_r  <= sb_s.cserr_n;
    end
  end

  default clocking cb_clk @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  abort_timeout_a: assert property ($rose(ans_r.abort) |->
    $past(cnt_r) == 3'h4 && $past(cb_s.devsel_n)) else $error("abort without full claim wait");
  claim_wait_a: assert property ((ini_r == cbsl_pkg::I_WAIT && cb_s.devsel_n)[*5] |=>
    ini_r != cbsl_pkg::I_WAIT) else $error("claim wait ran past five clocks");
  claim_devsel_a: assert property (tgt_r == cbsl_pkg::T_DATA |->
    !cb_o_r.devsel_n && !oe_r.devsel_n) else $error("claimed cycle without device select");
  last_frame_a: assert property (ini_r == cbsl_pkg::I_DATA && !cb_o_r.frame_n |->
    rem_r != cbsl_pkg::LEN_ONE) else $error("frame held on last phase");
  wait_state_a: assert property ((ini_r == cbsl_pkg::I_WAIT || ini_r == cbsl_pkg::I_DATA) && !ini_xfer |=>
    rem_r == $past(rem_r)) else $error("phase counted without both ready");
  perr_two_a: assert property (tgt_xfer ##1 (par_calc_r != par_s) |=>
    !cb_o_r.perr_n && !oe_r.perr_n) else $error("parity error not driven two clocks later");
  grant_idle_a: assert property ($fell(gnt_n_r) |->
    $past(ini_r) == cbsl_pkg::I_IDLE && $past(bus_idle)) else $error("grant during transaction");
  serr_relay_a: assert property (serr_en && $fell(sb_s.cserr_n) |=>
    !st_r.pci_serr_n ##1 st_r.pci_serr_n) else $error("system error not relayed as pulse");
  audio_pass_a: assert property (audio_bin_en |=>
    st_r.speaker_out == $past(sb_s.caudio)) else $error("audio not passed to speaker");
  gpi_reset_a: assert property (!lock_fn_r |->
    oe_r.lock_n && cb_o_r.lock_n) else $error("lock pin driven while general purpose");
  lock_region_a: assert property (ans_r.retry |->
    $past(lock_act_r)) else $error("retry without active lock");
  lock_hold_a: assert property (lock_act_r |->
    !cb_o_r.lock_n && !st_r.posting_en) else $error("lock not forwarded or posting left on");

  abort_seen_c: cover property ($rose(ans_r.abort));
  burst_done_c: cover property (ini_r == cbsl_pkg::I_DATA ##1 $rose(ans_r.done));
  perr_seen_c: cover property ($fell(cb_o_r.perr_n));
  retry_seen_c: cover property ($rose(ans_r.retry));

endmodule

// file: design/cbsl_pkg.sv
// Shared types and constants for the CardBus socket signalling block.
// Assumes one clock domain, the CardBus clock, and active-low bus pins.
package cbsl_pkg;

  // Clocks that the initiator waits for a claim before it aborts.
  localparam logic [2:0]  DEVSEL_TO_CLKS = 3'h5;
  // Command code of a special cycle, which is never claimed.
  localparam logic [3:0]  CMD_SPECIAL    = 4'h1;
  // Lowest address bit above the 16-byte lock granule.
  localparam int          LOCK_LSB       = 4;
  // Lowest address bit of the target decode.
  localparam int          TGT_LSB        = 16;
  localparam logic [3:0]  LEN_ONE        = 4'h1;

  typedef struct packed {
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic devsel_n;
    logic stop_n;
    logic perr_n;
    logic lock_n;
  } cbsl_ctl_s;
  localparam cbsl_ctl_s CTL_RST = 7'h7f;

  typedef struct packed {
    logic cstschg;
    logic cint_n;
    logic cserr_n;
    logic creq_n;
    logic caudio;
    logic cd1_n;
    logic cd2_n;
    logic vs1;
    logic vs2;
    logic gp2;
  } cbsl_sb_s;
  localparam cbsl_sb_s SB_RST = 10'h1d9;

  typedef struct packed {
    logic       card_irq;
    logic       stschg;
    logic       wake;
    logic       present;
    logic [1:0] vs;
    logic       general_purpose_input;
    logic       posting_en;
    logic       speaker_out;
    logic       pci_serr_n;
  } cbsl_st_s;
  localparam cbsl_st_s ST_RST = 10'h005;

  typedef struct packed {
    logic busy;
    logic done;
    logic abort;
    logic retry;
  } cbsl_ans_s;
  localparam cbsl_ans_s ANS_RST = 4'h0;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [3:0]  len;
    logic        locked;
  } cbsl_req_s;
  localparam cbsl_req_s REQ_RST = 41'h0;

  typedef enum logic [2:0] {
    I_IDLE = 3'h0,
    I_ADDR = 3'h1,
    I_WAIT = 3'h2,
    I_DATA = 3'h3,
    I_END  = 3'h4
  } cbsl_ini_e;

  typedef enum logic [1:0] {
    T_IDLE = 2'h0,
    T_DATA = 2'h1,
    T_END  = 2'h2
  } cbsl_tgt_e;

endpackage

// file: testbench/cbsl_card.sv
// Card controller model acting as a CardBus target for cycles the socket starts.
// Assumes pins are resolved by the bench with pullups; released lines read high.
`timescale 1ns/10ps
module cbsl_card (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                claim_en,
  input  wire logic                disc_en,
  input  wire cbsl_pkg::cbsl_ctl_s cb,
  output cbsl_pkg::cbsl_ctl_s      o,
  output cbsl_pkg::cbsl_ctl_s      oe_n
);
  logic [1:0] st_r;
  logic       fr_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= 2'h0;
      fr_r <= 1'b1;
      o    <= cbsl_pkg::CTL_RST;
      oe_n <= cbsl_pkg::CTL_RST;
    end else begin
      fr_r <= cb.frame_n;
      case (st_r)
        2'h0: if (fr_r && !cb.frame_n && claim_en) begin
          o.devsel_n    <= 1'b0;
          o.trdy_n      <= 1'b0;
          oe_n.devsel_n <= 1'b0;
          oe_n.trdy_n   <= 1'b0;
          o.stop_n      <= !disc_en;
          oe_n.stop_n   <= !disc_en;
          st_r          <= 2'h1;
        end
        // The phase in progress when frame rises is the last one, so the claim is dropped then.
        2'h1: if (cb.frame_n) begin
          o    <= cbsl_pkg::CTL_RST;
          st_r <= 2'h2;
        end
        default: begin
          oe_n <= cbsl_pkg::CTL_RST;
          st_r <= 2'h0;
        end
      endcase
    end
  end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the socket signalling block with a card target model.
// Assumes a single 10 MHz clock; the bench plays the card initiator and sideband pins.
`timescale 1ns/10ps
module testbench;
  logic                clk, rst_n, par_i, ad_oe_n, cgnt_n, req_valid;
  logic                lock_fn_en, serr_en, audio_bin_en, claim_en, disc_en;
  cbsl_pkg::cbsl_ctl_s cb_i, cb_o, cb_oe_n, card_o, card_oe_n, tb_o, tb_oe_n;
  logic [31:0]         ad_i, ad_o, tb_ad;
  logic [3:0]          cbe_i, cbe_o, tb_cbe, ph;
  cbsl_pkg::cbsl_sb_s  sb_i;
  cbsl_pkg::cbsl_req_s req;
  cbsl_pkg::cbsl_ans_s ans;
  cbsl_pkg::cbsl_st_s  st;
  logic [1:0]          r;
  int                  error_cnt, compares, cyc, fr_cnt, t, k;
  // Every control pin has a pullup, so a released line reads high.
  assign cb_i  = (cb_o | cb_oe_n) & (card_o | card_oe_n) & (tb_o | tb_oe_n);
  assign ad_i  = ad_oe_n ? tb_ad : ad_o;
  assign cbe_i = ad_oe_n ? tb_cbe : cbe_o;
  cbsl_top dut (.clk(clk), .rst_n(rst_n), .cb_i(cb_i), .cb_o(cb_o), .cb_oe_n(cb_oe_n),
    .ad_i(ad_i), .cbe_i(cbe_i), .par_i(par_i), .ad_o(ad_o), .cbe_o(cbe_o), .ad_oe_n(ad_oe_n),
    .sb_i(sb_i), .cgnt_n(cgnt_n), .tgt_base(16'h8000), .req_valid(req_valid), .req(req),
    .ans(ans), .lock_fn_en(lock_fn_en), .serr_en(serr_en), .audio_bin_en(audio_bin_en), .st(st));
  cbsl_card card (.clk(clk), .rst_n(rst_n), .claim_en(claim_en), .disc_en(disc_en), .cb(cb_i),
    .o(card_o), .oe_n(card_oe_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      print_verdict();
    end
  end
  always @(negedge clk) if (cb_oe_n.frame_n === 1'b0 && cb_o.frame_n === 1'b0) fr_cnt++;
  task automatic print_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    compares++;
    if (c !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Result r: 1 done, 2 abort, 3 retry; t counts cycles from busy to the answer.
  task automatic do_req(input logic [31:0] a, input logic lk);
    int n;
    @(negedge clk);
    req = '{addr: a, cmd: 4'h6, len: ph, locked: lk};
    req_valid = 1'b1;
    r = 2'h0;
    for (n = 0; n < 20 && ans.busy !== 1'b1 && ans.retry !== 1'b1; n++) @(negedge clk);
    req_valid = 1'b0;
    if (ans.retry === 1'b1) r = 2'h3;
    for (t = 0; t < 60 && r == 2'h0; t++) begin
      @(negedge clk);
      if (ans.done === 1'b1) r = 2'h1;
      if (ans.abort === 1'b1) r = 2'h2;
    end
    for (n = 0; n < 10 && ans.busy !== 1'b0; n++) @(negedge clk);
    cyc_n(3);
  endtask
  task automatic t_reset();
    chk(cb_oe_n === cbsl_pkg::CTL_RST && ad_oe_n === 1'b1 && cgnt_n === 1'b1, "pins not released");
    chk(ans === cbsl_pkg::ANS_RST && st === cbsl_pkg::ST_RST, "reset outputs wrong");
    $display("test reset done");
  endtask
  task automatic t_init();
    claim_en = 1'b1;
    fr_cnt = 0;
    do_req(32'h0000_1000, 1'b0);
    chk(r == 2'h1, "claimed cycle not done");
    chk(fr_cnt == 1, "frame low count wrong for one phase");
    claim_en = 1'b0;
    do_req(32'h0000_1004, 1'b0);
    chk(r == 2'h2, "unclaimed cycle not aborted");
    chk(t >= int'(cbsl_pkg::DEVSEL_TO_CLKS), "abort came too early");
    $display("test initiator done");
  endtask
  // A three-phase burst runs to its end, then the same burst is cut short by a disconnect.
  task automatic t_burst();
    int t0;
    claim_en = 1'b1;
    ph = 4'h3;
    fr_cnt = 0;
    do_req(32'h0000_3000, 1'b0);
    chk(r == 2'h1 && fr_cnt > 1, "burst not done with frame held");
    t0 = t;
    disc_en = 1'b1;
    do_req(32'h0000_3040, 1'b0);
    chk(r == 2'h1 && t < t0, "disconnect did not end the burst");
    {ph, disc_en, claim_en} = {cbsl_pkg::LEN_ONE, 1'b0, 1'b0};
    $display("test burst done");
  endtask
  task automatic t_target(input logic [31:0] a, input logic [3:0] c, input logic hit);
    int n;
    @(negedge clk);
    tb_ad = a;
    tb_cbe = c;
    tb_o.frame_n = 1'b0;
    tb_o.irdy_n = 1'b1;
    tb_oe_n.frame_n = 1'b0;
    tb_oe_n.irdy_n = 1'b0;
    for (n = 0; n < 8 && cb_i.devsel_n !== 1'b0; n++) @(negedge clk);
    chk((cb_oe_n.devsel_n === 1'b0) == hit, "claim decision wrong");
    tb_o.frame_n = 1'b1;
    tb_o.irdy_n = 1'b0;
    tb_ad = 32'h1234_5678;
    tb_cbe = 4'h0;
    // Wrong parity is held, so the error shows whichever edge the target samples.
    par_i = ~(^{tb_ad, tb_cbe});
    for (n = 0; n < 10 && cb_i.perr_n !== 1'b0; n++) @(negedge clk);
    if (hit) chk(cb_oe_n.perr_n === 1'b0 && cb_o.perr_n === 1'b0, "no parity error report");
    else chk(cb_oe_n.perr_n === 1'b1, "parity error on unclaimed cycle");
    cyc_n(6);
    tb_o = cbsl_pkg::CTL_RST;
    cyc_n(1);
    tb_oe_n = cbsl_pkg::CTL_RST;
    cyc_n(6);
    chk(cb_oe_n.devsel_n === 1'b1 && cb_oe_n.trdy_n === 1'b1, "target pins not released");
    $display("test target done");
  endtask
  task automatic t_arb();
    int n;
    sb_i.creq_n = 1'b0;
    for (n = 0; n < 8 && cgnt_n !== 1'b0; n++) @(negedge clk);
    chk(cgnt_n === 1'b0, "no grant");
    chk(cb_oe_n.lock_n === 1'b1 && st.posting_en === 1'b1, "grant took the lock");
    sb_i.creq_n = 1'b1;
    for (n = 0; n < 8 && cgnt_n !== 1'b1; n++) @(negedge clk);
    chk(cgnt_n === 1'b1, "grant not removed");
    $display("test arbiter done");
  endtask
  task automatic t_lock();
    lock_fn_en = 1'b1;
    sb_i.gp2 = 1'b0;
    claim_en = 1'b1;
    cyc_n(4);
    do_req(32'h0000_2010, 1'b1);
    chk(r == 2'h1, "locked request failed");
    chk(cb_oe_n.lock_n === 1'b0 && cb_o.lock_n === 1'b0, "card lock not held");
    chk(st.posting_en === 1'b0, "posting still on");
    do_req(32'h0000_201c, 1'b0);
    chk(r == 2'h3, "locked granule not refused");
    do_req(32'h0000_2020, 1'b0);
    chk(r == 2'h1, "outside access blocked");
    sb_i.gp2 = 1'b1;
    cyc_n(6);
    chk(st.posting_en === 1'b1, "posting not restored");
    lock_fn_en = 1'b0;
    claim_en = 1'b0;
    $display("test lock done");
  endtask
  task automatic t_side();
    sb_i.cint_n = 1'b0;
    audio_bin_en = 1'b1;
    sb_i.caudio = 1'b1;
    {sb_i.cd1_n, sb_i.cd2_n, sb_i.vs1, sb_i.vs2, sb_i.gp2} = 5'h04;
    cyc_n(5);
    chk(st.card_irq === 1'b1 && st.speaker_out === 1'b1, "irq or audio lost");
    chk(st.present === 1'b1 && st.vs === 2'h1 && st.general_purpose_input === 1'b0, "sense wrong");
    sb_i.caudio = 1'b0;
    {sb_i.cd2_n, sb_i.gp2} = 2'h3;
    cyc_n(5);
    chk(st.speaker_out === 1'b0 && st.present === 1'b0 && st.vs === 2'h0, "removal wrong");
    chk(st.general_purpose_input === 1'b1, "input pin not followed");
    sb_i.cstschg = 1'b1;
    k = 0;
    repeat (8) begin
      @(negedge clk);
      if (st.wake === 1'b1) k++;
    end
    chk(k == 1 && st.stschg === 1'b1, "status change wake wrong");
    serr_en = 1'b1;
    sb_i.cserr_n = 1'b0;
    k = 0;
    repeat (10) begin
      @(negedge clk);
      if (st.pci_serr_n === 1'b0) k++;
    end
    chk(k == 1, "system error relay count wrong");
    sb_i.cserr_n = 1'b1;
    $display("test sideband done");
  endtask
  initial begin
    {rst_n, par_i, req_valid, lock_fn_en, serr_en, audio_bin_en, claim_en, disc_en} = 8'h00;
    {sb_i, tb_o, tb_oe_n} = {cbsl_pkg::SB_RST, cbsl_pkg::CTL_RST, cbsl_pkg::CTL_RST};
    {tb_ad, tb_cbe, req, ph} = {32'h0, 4'h0, cbsl_pkg::REQ_RST, cbsl_pkg::LEN_ONE};
    {error_cnt, compares, cyc, fr_cnt} = {32'h0, 32'h0, 32'h0, 32'h0};
    cyc_n(12);
    t_reset();
    rst_n = 1'b1;
    cyc_n(4);
    t_init();
    t_burst();
    t_target(32'h8000_0040, 4'h7, 1'b1);
    t_target(32'h8000_0080, cbsl_pkg::CMD_SPECIAL, 1'b0);
    t_target(32'h4000_0040, 4'h6, 1'b0);
    t_arb();
    t_lock();
    t_side();
    print_verdict();
  end
endmodule
